// ---- dv/irf_periph_model.sv ----
// Timers, converter and pins feeding the request flag block.
// Assumes go_i pulses one cycle, at least four cycles apart.
`timescale 1ns/1ns
module irf_periph_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Event request
    input wire logic go_i,
    input wire logic [4:0] src_i,
    // Sources
    output logic [5:0] pin_o,
    output logic [7:0] ta_o,
    output logic [7:0] tc_o,
    output logic [7:0] fh_o,
    output logic [7:0] fl_o,
    output logic [4:0] pulse_o
);
    logic [1:0] st_q;
    logic [4:0] src_q;
    logic pre;
    logic post;
    assign pre = st_q == 2'd1;
    assign post = st_q == 2'd2;
    assign ta_o = src_q != 5'd0 ? 8'h10 : pre ? 8'hFF : post ? 8'h00 : 8'h10;
    assign tc_o = src_q == 5'd10 ? (pre ? 8'hFF : post ? 8'h00 : 8'h10) :
        src_q == 5'd11 ? (pre ? 8'h00 : post ? 8'hFF : 8'h10) : 8'h10;
    assign fh_o = pre && (src_q == 5'd8 || src_q == 5'd16) ? 8'hA5 : 8'h01;
    assign fl_o = pre && (src_q == 5'd9 || src_q == 5'd16) ? 8'h5A : 8'h02;
    assign pulse_o = pre ? {src_q == 5'd15, src_q == 5'd14, src_q == 5'd13,
        src_q == 5'd12, src_q == 5'd7} : 5'h00;
    // Pins idle high; one toggles per request from sources 1 to 6
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= 2'd0;
            src_q <= 5'd31;
            pin_o <= 6'h3F;
        end else if (go_i) begin
            st_q <= 2'd1;
            src_q <= src_i;
            if (src_i >= 5'd1 && src_i <= 5'd6) pin_o[src_i - 5'd1] <= ~pin_o[src_i - 5'd1];
        end else if (st_q != 2'd0) begin
            st_q <= st_q + 2'd1;
        end
    end
endmodule : irf_periph_model

// ---- dv/irf_sva.sv ----
// Port checks for the request flag block.
// Bound to irf_top; one clock, synchronous active-high reset.
`timescale 1ns/1ns
module irf_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus and sources
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] timer_a_count_i,
    input wire logic [7:0] req_one_o,
    input wire logic [7:0] req_two_o
);
    logic [7:0] ta_q;
    logic [2:0] wr_q;
    logic [2:0] wrap_q;
    logic rd_one;
    assign rd_one = wb_ack_o && !wb_we_i && wb_adr_i == irf_pkg::ADR_REQ_ONE;
    // Recent writes and timer A wraps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ta_q <= 8'h00;
            wr_q <= 3'h0;
            wrap_q <= 3'h0;
        end else begin
            ta_q <= timer_a_count_i;
            wr_q <= {wr_q[1:0], wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o};
            wrap_q <= {wrap_q[1:0], ta_q == 8'hFF && timer_a_count_i == 8'h00};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_fixed_one: assert property (rd_one |-> wb_dat_o[5] && wb_dat_o[31:8] == 24'h0)
        else $error("fixed bit not read as one");
    a_spare_quiet: assert property (req_one_o[6:5] == 2'b00 && !req_two_o[5])
        else $error("storage bit on request output");
    a_reset_clear: assert property ($fell(rst_i) |-> {req_one_o, req_two_o} == 16'h0)
        else $error("request not clear after reset");
    a_no_self_clear: assert property ((|($past(req_one_o) & ~req_one_o)) ||
        (|($past(req_two_o) & ~req_two_o)) |-> |wr_q)
        else $error("request dropped without a write");
    a_wrap_cause: assert property ($rose(req_one_o[7]) |-> |{wrap_q, wr_q})
        else $error("timer A request without wrap");
    a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved between accesses");
endmodule : irf_sva

// ---- dv/irf_top_tb.sv ----
// Self-checking bench for the request flag block.
// Drives the bus and the peripheral model from a fixed seed.
`timescale 1ns/1ns
module irf_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic ack;
    logic [4:0] cfg = 5'h00;
    logic ccfg = 1'b0;
    logic [3:0] mode = 4'h0;
    logic go = 1'b0;
    logic [4:0] src = 5'd0;
    logic [5:0] pin;
    logic [7:0] ta, tc, fh, fl, req1, req2;
    logic [4:0] pls;
    int error_cnt = 0;
    int check_count = 0;
    always #50 clk_i = ~clk_i;
    irf_top u_irf_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_int_pin_i(pin[4:0]), .ext_pin_cfg_i(cfg),
        .timer_g_capture_pin_i(pin[5]), .timer_g_capture_cfg_i(ccfg), .timer_a_count_i(ta),
        .timer_c_count_i(tc), .timer_g_overflow_i(pls[0]), .overflow_irq_enable_i(mode[0]),
        .timer_f_16bit_i(mode[1]), .timer_f_count_high_i(fh), .timer_f_count_low_i(fl),
        .timer_f_compare_high_i(8'hA5), .timer_f_compare_low_i(8'h5A),
        .event_count_16bit_i(mode[2]), .event_count_high_ovf_i(pls[1]),
        .event_count_low_ovf_i(pls[2]), .conversion_start_flag_i(pls[3]),
        .direct_xfer_i(pls[4]), .direct_xfer_on_i(mode[3]), .req_one_o(req1), .req_two_o(req2));
    irf_periph_model u_irf_periph_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .src_i(src),
        .pin_o(pin), .ta_o(ta), .tc_o(tc), .fh_o(fh), .fl_o(fl), .pulse_o(pls));
    function automatic logic [15:0] expect_flags(input logic [4:0] s, input logic lvl,
        input logic [5:0] es);
        logic [15:0] e;
        e = 16'h0;
        case (s)
            5'd0: e[7] = 1'b1;
            5'd1, 5'd2, 5'd3, 5'd4, 5'd5:
                e[s - 5'd1] = cfg[s - 5'd1] && es[s - 5'd1] == !lvl;
            5'd6: e[12] = ccfg && es[5] == !lvl;
            5'd7: e[12] = mode[0];
            5'd8, 5'd9: e[5'd19 - s] = !mode[1];
            5'd16: e[11:10] = {1'b1, !mode[1]};
            5'd10, 5'd11: e[9] = 1'b1;
            5'd12: e[8] = 1'b1;
            5'd13: e[8] = !mode[2];
            5'd14: e[14] = 1'b1;
            default: e[15] = mode[3];
        endcase
        return e;
    endfunction : expect_flags
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
    endtask : wb
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 8'h00);
        chk($sformatf("reg_%h", a), x, got);
    endtask : rc
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end
    initial begin
        int s;
        logic [7:0] e1;
        logic [7:0] e2;
        logic [15:0] e;
        logic [5:0] es;
        logic lvl;
        s = $urandom(32'h64DD0C2E);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(irf_pkg::ADR_REQ_ONE, 32'h20);
        rc(irf_pkg::ADR_REQ_TWO, 32'h0);
        rc(irf_pkg::ADR_EDGE_SEL, 32'h0);
        rc(8'h14, 32'h0);
        for (int i = 0; i < 90; i++) begin
            s = i < 17 ? i : $urandom % 17;
            mode <= 4'($urandom);
            cfg <= 5'($urandom);
            ccfg <= 1'($urandom);
            e1 = 8'($urandom);
            e2 = 8'($urandom);
            es = i < 17 ? 6'h00 : 6'($urandom);
            wb(1'b1, irf_pkg::ADR_ENA_ONE, e1);
            wb(1'b1, irf_pkg::ADR_ENA_TWO, e2);
            wb(1'b1, irf_pkg::ADR_EDGE_SEL, {2'b00, es});
            wb(1'b1, irf_pkg::ADR_REQ_ONE, 8'h00);
            wb(1'b1, irf_pkg::ADR_REQ_TWO, 8'h00);
            lvl = pin[(s + 5) % 6];
            @(posedge clk_i);
            go <= 1'b1;
            src <= 5'(s);
            @(posedge clk_i);
            go <= 1'b0;
            repeat (6) @(posedge clk_i);
            e = expect_flags(5'(s), lvl, es) & {e2, e1};
            rc(irf_pkg::ADR_REQ_ONE, {24'h0, e[7:0] | 8'h20});
            rc(irf_pkg::ADR_REQ_TWO, {24'h0, e[15:8]});
            chk("req", {16'h0, e}, {16'h0, req2, req1});
            wb(1'b1, irf_pkg::ADR_REQ_ONE, 8'hFF);
            wb(1'b1, irf_pkg::ADR_REQ_TWO, 8'hFF);
            rc(irf_pkg::ADR_REQ_ONE, {24'h0, e[7:0] | 8'h60});
            rc(irf_pkg::ADR_REQ_TWO, {24'h0, e[15:8] | 8'h20});
        end
        // Clear taken on the very edge of a timer A wrap: the set wins
        wb(1'b1, irf_pkg::ADR_ENA_ONE, 8'h80);
        @(posedge clk_i);
        go <= 1'b1;
        src <= 5'd0;
        @(posedge clk_i);
        go <= 1'b0;
        wb(1'b1, irf_pkg::ADR_REQ_ONE, 8'h00);
        rc(irf_pkg::ADR_REQ_ONE, 32'hA0);
        print_verdict();
    end
endmodule : irf_top_tb
bind irf_top irf_sva u_irf_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_a_count_i(timer_a_count_i), .req_one_o(req_one_o),
    .req_two_o(req_two_o));

// ---- rtl/irf_edge_det.sv ----
// Per-lane edge detector for the external request and capture pins.
// Assumes synchronous inputs; produces one-cycle edge pulses.
`timescale 1ns/1ns
module irf_edge_det (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin lanes
    irf_edge_if.det eif
);

    logic [5:0] prev_q;
    logic prev_ok_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 6'h00;
            prev_ok_q <= 1'b0;
        end else begin
            prev_q <= eif.level;
            prev_ok_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Edge selection, falling when select is 0
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < irf_pkg::EDGE_LANES; g++) begin : g_lane
            assign eif.edge_seen[g] = prev_ok_q && eif.pin_cfg[g] && (eif.rise_sel[g] ?
                (!prev_q[g] && eif.level[g]) :
                (prev_q[g] && !eif.level[g]));
        end
    endgenerate

endmodule : irf_edge_det

// ---- rtl/irf_edge_if.sv ----
// Bundle between the register block and its pin edge detector.
// Assumes pin levels are already synchronous to the system clock.
`timescale 1ns/1ns
interface irf_edge_if;
    logic [5:0] level;
    logic [5:0] rise_sel;
    logic [5:0] pin_cfg;
    logic [5:0] edge_seen;

    modport regs (output level, output rise_sel, output pin_cfg, input edge_seen);
    modport det (input level, input rise_sel, input pin_cfg, output edge_seen);
endinterface : irf_edge_if

// ---- rtl/irf_pkg.sv ----
// Constants of the interrupt request flag block.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
package irf_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_REQ_ONE = 8'h00;
    localparam logic [7:0] ADR_REQ_TWO = 8'h04;
    localparam logic [7:0] ADR_ENA_ONE = 8'h08;
    localparam logic [7:0] ADR_ENA_TWO = 8'h0C;
    localparam logic [7:0] ADR_EDGE_SEL = 8'h10;

    // ------------------------------------------------------------
    // Field positions, first request register
    // ------------------------------------------------------------
    localparam int ONE_TIMER_A = 7;
    localparam int ONE_SPARE = 6;
    localparam int ONE_FIXED = 5;
    localparam int EXT_PINS = 5;

    // ------------------------------------------------------------
    // Field positions, second request register
    // ------------------------------------------------------------
    localparam int TWO_DIRECT = 7;
    localparam int TWO_CONVERTER = 6;
    localparam int TWO_SPARE = 5;
    localparam int TWO_TIMER_G = 4;
    localparam int TWO_TIMER_FH = 3;
    localparam int TWO_TIMER_FL = 2;
    localparam int TWO_TIMER_C = 1;
    localparam int TWO_EVENT = 0;

    // ------------------------------------------------------------
    // Edge detector lanes: five external pins, then capture pin
    // ------------------------------------------------------------
    localparam int EDGE_LANES = 6;
    localparam int LANE_CAPTURE = 5;

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ONE_FLAG_MASK = 8'h9F;
    localparam logic [7:0] TWO_FLAG_MASK = 8'hDF;
    localparam logic [7:0] ONE_FIXED_VAL = 8'h20;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [5:0] EDGE_SEL_RESET = 6'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_MIN = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : irf_pkg

// ---- rtl/irf_top.sv ----
// Interrupt request flag registers with a classic Wishbone slave port.
// Assumes all event inputs are synchronous to clk_i.
//
// Contract
// - Timer A flag sets when timer A count wraps from FF to 00.
// - External pin flag sets on selected edge of a pin configured for interrupts.
// - Accepting an interrupt never clears a flag; only software clears.
// - Writing 0 clears a flag; writing 1 never sets it.
// - Bit 5 of first register always reads 1, writes ignored.
// - Bit 6 of first and bit 5 of second are plain storage, reset 0.
// - Direct transfer flag sets on sleep direct transfer while enabled.
// - Converter flag sets when conversion ends and start flag falls.
// - Timer G flag sets on capture edge or counter overflow with overflow enable.
// - Timer FH flag sets on high match in 8-bit, full match in 16-bit.
// - Timer FL flag sets on low match in 8-bit mode only.
// - Timer C flag sets on up wrap FF to 00 or down wrap 00 to FF.
// - Event counter flag sets on high overflow, or either overflow in 8-bit.
// - Edge select 0 means falling edge, 1 rising; reset value 0.
// - A request is taken only while its enable bit is 1.
`timescale 1ns/1ns
module irf_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External pins and their port configuration
    input wire logic [4:0] ext_int_pin_i,
    input wire logic [4:0] ext_pin_cfg_i,
    input wire logic timer_g_capture_pin_i,
    input wire logic timer_g_capture_cfg_i,
    // Timers
    input wire logic [7:0] timer_a_count_i,
    input wire logic [7:0] timer_c_count_i,
    input wire logic timer_g_overflow_i,
    input wire logic overflow_irq_enable_i,
    input wire logic timer_f_16bit_i,
    input wire logic [7:0] timer_f_count_high_i,
    input wire logic [7:0] timer_f_count_low_i,
    input wire logic [7:0] timer_f_compare_high_i,
    input wire logic [7:0] timer_f_compare_low_i,
    // Event counter
    input wire logic event_count_16bit_i,
    input wire logic event_count_high_ovf_i,
    input wire logic event_count_low_ovf_i,
    // Converter and direct transfer
    input wire logic conversion_start_flag_i,
    input wire logic direct_xfer_i,
    input wire logic direct_xfer_on_i,
    // Requests to priority logic
    output logic [7:0] req_one_o,
    output logic [7:0] req_two_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] flags_one_q;
    logic [7:0] flags_two_q;
    logic spare_one_q;
    logic spare_two_q;
    logic [7:0] ena_one_q;
    logic [7:0] ena_two_q;
    logic [5:0] edge_sel_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [7:0] req_one_q;
    logic [7:0] req_two_q;

    logic [7:0] ta_prev_q;
    logic [7:0] tc_prev_q;
    logic tc_prev_ok_q;
    logic fh_match_prev_q;
    logic fl_match_prev_q;
    logic conversion_start_flag_prev_q;

    logic access;
    logic wr_lane0;
    logic wr_one;
    logic wr_two;
    logic [7:0] clr_one;
    logic [7:0] clr_two;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] view_one;
    logic [7:0] view_two;
    logic fh_match;
    logic fl_match;
    logic [7:0] rd_byte;

    irf_edge_if eif ();

    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    assign eif.level = {timer_g_capture_pin_i, ext_int_pin_i};
    assign eif.pin_cfg = {timer_g_capture_cfg_i, ext_pin_cfg_i};
    assign eif.rise_sel = edge_sel_q;

    irf_edge_det u_edge (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .eif (eif.det)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign access = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lane0 = access && wb_we_i && wb_sel_i[0];
    assign wr_one = wr_lane0 && (wb_adr_i == irf_pkg::ADR_REQ_ONE);
    assign wr_two = wr_lane0 && (wb_adr_i == irf_pkg::ADR_REQ_TWO);

    // Writing 0 clears, writing 1 leaves the flag alone
    assign clr_one = wr_one ? (~wb_dat_i[7:0] & irf_pkg::ONE_FLAG_MASK) :
        irf_pkg::REG_RESET;
    assign clr_two = wr_two ? (~wb_dat_i[7:0] & irf_pkg::TWO_FLAG_MASK) :
        irf_pkg::REG_RESET;

    // ------------------------------------------------------------
    // Event conditions
    // ------------------------------------------------------------
    assign fh_match = timer_f_16bit_i ?
        ({timer_f_count_high_i, timer_f_count_low_i} ==
         {timer_f_compare_high_i, timer_f_compare_low_i}) :
        (timer_f_count_high_i == timer_f_compare_high_i);
    assign fl_match = !timer_f_16bit_i &&
        (timer_f_count_low_i == timer_f_compare_low_i);

    always_comb begin
        set_one = irf_pkg::REG_RESET;
        set_one[irf_pkg::ONE_TIMER_A] = (ta_prev_q == irf_pkg::CNT_MAX) &&
            (timer_a_count_i == irf_pkg::CNT_MIN);
        set_one[irf_pkg::EXT_PINS-1:0] = eif.edge_seen[irf_pkg::EXT_PINS-1:0];
        set_one = set_one & ena_one_q;
    end

    always_comb begin
        set_two = irf_pkg::REG_RESET;
        set_two[irf_pkg::TWO_DIRECT] = direct_xfer_i && direct_xfer_on_i;
        set_two[irf_pkg::TWO_CONVERTER] = conversion_start_flag_prev_q && !conversion_start_flag_i;
        set_two[irf_pkg::TWO_TIMER_G] = eif.edge_seen[irf_pkg::LANE_CAPTURE] ||
            (timer_g_overflow_i && overflow_irq_enable_i);
        set_two[irf_pkg::TWO_TIMER_FH] = fh_match && !fh_match_prev_q;
        set_two[irf_pkg::TWO_TIMER_FL] = fl_match && !fl_match_prev_q;
        set_two[irf_pkg::TWO_TIMER_C] = tc_prev_ok_q &&
            (((tc_prev_q == irf_pkg::CNT_MAX) && (timer_c_count_i == irf_pkg::CNT_MIN)) ||
             ((tc_prev_q == irf_pkg::CNT_MIN) && (timer_c_count_i == irf_pkg::CNT_MAX)));
        // Line above covers both wrap directions
        set_two[irf_pkg::TWO_EVENT] = event_count_high_ovf_i ||
            (!event_count_16bit_i && event_count_low_ovf_i);
        set_two = set_two & ena_two_q;
    end

    // ------------------------------------------------------------
    // Event history
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ta_prev_q <= irf_pkg::CNT_MIN;
            tc_prev_q <= irf_pkg::CNT_MIN;
            tc_prev_ok_q <= 1'b0;
            fh_match_prev_q <= 1'b1;
            fl_match_prev_q <= 1'b1;
            conversion_start_flag_prev_q <= 1'b0;
        end else begin
            ta_prev_q <= timer_a_count_i;
            tc_prev_q <= timer_c_count_i;
            tc_prev_ok_q <= 1'b1;
            fh_match_prev_q <= fh_match;
            fl_match_prev_q <= fl_match;
            conversion_start_flag_prev_q <= conversion_start_flag_i;
        end
    end

    // ------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_one_q <= irf_pkg::REG_RESET;
            flags_two_q <= irf_pkg::REG_RESET;
        end else begin
            // No acceptance input: only a bus clear lowers a flag
            flags_one_q <= (flags_one_q & ~clr_one) | set_one;
            flags_two_q <= (flags_two_q & ~clr_two) | set_two;
        end
    end

    // ------------------------------------------------------------
    // Storage and control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spare_one_q <= 1'b0;
            spare_two_q <= 1'b0;
        end else begin
            if (wr_one) begin
                spare_one_q <= wb_dat_i[irf_pkg::ONE_SPARE];
            end
            if (wr_two) begin
                spare_two_q <= wb_dat_i[irf_pkg::TWO_SPARE];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ena_one_q <= irf_pkg::REG_RESET;
            ena_two_q <= irf_pkg::REG_RESET;
            edge_sel_q <= irf_pkg::EDGE_SEL_RESET;
        end else if (wr_lane0) begin
            case (wb_adr_i)
                irf_pkg::ADR_ENA_ONE: begin
                    ena_one_q <= wb_dat_i[7:0];
                end
                irf_pkg::ADR_ENA_TWO: begin
                    ena_two_q <= wb_dat_i[7:0];
                end
                irf_pkg::ADR_EDGE_SEL: begin
                    edge_sel_q <= wb_dat_i[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    always_comb begin
        view_one = flags_one_q & irf_pkg::ONE_FLAG_MASK;
        view_one[irf_pkg::ONE_SPARE] = spare_one_q;
        view_one = view_one | irf_pkg::ONE_FIXED_VAL;
        view_two = flags_two_q & irf_pkg::TWO_FLAG_MASK;
        view_two[irf_pkg::TWO_SPARE] = spare_two_q;
    end

    always_comb begin
        case (wb_adr_i)
            irf_pkg::ADR_REQ_ONE: rd_byte = view_one;
            irf_pkg::ADR_REQ_TWO: rd_byte = view_two;
            irf_pkg::ADR_ENA_ONE: rd_byte = ena_one_q;
            irf_pkg::ADR_ENA_TWO: rd_byte = ena_two_q;
            irf_pkg::ADR_EDGE_SEL: rd_byte = {2'h0, edge_sel_q};
            default: rd_byte = irf_pkg::REG_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= irf_pkg::DATA_ZERO;
        end else begin
            ack_q <= access;
            if (access) begin
                rdat_q <= {24'h000000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // Requests to priority logic
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_one_q <= irf_pkg::REG_RESET;
            req_two_q <= irf_pkg::REG_RESET;
        end else begin
            req_one_q <= flags_one_q & ena_one_q & irf_pkg::ONE_FLAG_MASK;
            req_two_q <= flags_two_q & ena_two_q & irf_pkg::TWO_FLAG_MASK;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign req_one_o = req_one_q;
    assign req_two_o = req_two_q;

endmodule : irf_top
